/* core/phy_mgmt_defines.svh */
// register offsets, field positions, reset values and timing of the phy management set
`ifndef PHY_MGMT_DEFINES_SVH
`define PHY_MGMT_DEFINES_SVH

`define OFS_BASIC_CONTROL     5'h00
`define OFS_BASIC_STATUS      5'h01
`define OFS_PHY_ID_HIGH       5'h02
`define OFS_PHY_ID_LOW        5'h03
`define OFS_NEG_ADVERT        5'h04
`define OFS_PARTNER_ABILITY   5'h05
`define OFS_NEG_EXPANSION     5'h06
`define OFS_VENDOR_CONFIG     5'h10
`define OFS_VENDOR_CFG_STAT   5'h11
`define OFS_TEN_BASE_T_CFG    5'h12

`define CTRL_RESET_BIT        15
`define CTRL_LOOPBACK_BIT     14
`define CTRL_SPEED_BIT        13
`define CTRL_AN_ENABLE_BIT    12
`define CTRL_POWER_DOWN_BIT   11
`define CTRL_ISOLATE_BIT      10
`define CTRL_AN_RESTART_BIT   9
`define CTRL_DUPLEX_BIT       8
`define CTRL_COL_TEST_BIT     7
`define PARTNER_RF_BIT        13

`define RST_BASIC_CONTROL     16'h3100
`define RST_BASIC_STATUS      16'h7809
`define RST_NEG_ADVERT        16'h01e1
`define RST_VENDOR_CONFIG     16'h0000
`define RST_VENDOR_CFG_STAT   16'hf010
`define RST_TEN_BASE_T_CFG    16'h7800
`define MASK_NEG_ADVERT       16'h3dff
`define STATUS_CAPS           4'hf

`define PREAMBLE_ONES         32
`define HEADER_BITS           14
`define DATA_BITS             16

`define CLK_KHZ               100000
`define DEAD_TIME_MS          720
`define SOFT_RESET_CYCLES     16

`define HOST_MGMT_CTRL_ADDR   4'h0
`define HOST_MGMT_STAT_ADDR   4'h4
`define HOST_CLOCK_BIT        16
`define HOST_DATA_OUT_BIT     17
`define HOST_DRIVE_BIT        18
`define AXI_RESP_OKAY         2'b00
`define AXI_RESP_SLVERR       2'b10

`endif

/* core/phy_mgmt_pkg.sv */
// types shared by both ends of the management link
package phy_mgmt_pkg;
    typedef enum logic [1:0] {
        st_preamble,
        st_header,
        st_turn,
        st_data
    } frame_state_type;
endpackage

/* core/mdio_link_if.sv */
// management clock and data link between controller and phy
`timescale 1ns/1ps
`default_nettype none
interface mdio_link_if;
    logic mdc;
    logic host_o;
    logic host_oe;
    logic dev_o;
    logic dev_oe;
    logic mdio;

    // open line resolves to the pull-up level
    assign mdio = host_oe ? host_o : (dev_oe ? dev_o : 1'b1);

    modport host   (output mdc, output host_o, output host_oe, input mdio);
    modport device (input mdc, input mdio, output dev_o, output dev_oe);
endinterface
`default_nettype wire

/* core/phy_mgmt_regs.sv */
// phy management register set with its serial management frame engine
// Function
// - offsets 7-15 and unlisted read zero
// - control bit15 resets registers, reads one meanwhile
// - bit14 loopback; 100M gives 720ms receive dead time
// - bit13 speed; reads negotiated speed under negotiation
// - bit12 negotiation; else bits 8,13 force mode
// - bit11 powers down everything but management
// - bit10 isolates data interface, management stays live
// - bit9 restarts negotiation, self-clears once initiated
// - bit8 full duplex when forced, else negotiated
// - bit7 collision test echoes transmit enable
// - control bits 6-0 reserved, read zero
// - status capability bits fixed ones
// - status bit6 zero, preamble always required
// - status bit5 shows negotiation complete
// - status bit4 latches remote fault until read
// - status bit2 link latches low until read
// - status bit1 latches jabber, 10M only
// - status bits 10-7 reserved, read zero
// - host toggles clock and data bits
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "phy_mgmt_defines.svh"
module phy_mgmt_regs
    import phy_mgmt_pkg::*;
#(
    parameter logic [4:0]  PHY_ADDR     = 5'h01,
    parameter logic [15:0] ID_HIGH      = 16'h1234,   // arbitrary identity value
    parameter logic [15:0] ID_LOW       = 16'h5670,   // arbitrary identity value
    parameter int          DEAD_CYCLES  = `DEAD_TIME_MS * `CLK_KHZ,
    parameter int          RESET_CYCLES = `SOFT_RESET_CYCLES
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_reset,
    mdio_link_if.device      link,
    input  wire logic        i_link_up,
    input  wire logic        i_remote_fault,
    input  wire logic        i_jabber,
    input  wire logic        i_an_complete,
    input  wire logic        i_an_speed_100,
    input  wire logic        i_an_full_duplex,
    input  wire logic        i_an_initiated,
    input  wire logic [15:0] i_partner_ability,
    input  wire logic [15:0] i_neg_expansion,
    input  wire logic        i_tx_en,
    output logic             o_loopback,
    output logic             o_speed_100,
    output logic             o_full_duplex,
    output logic             o_an_enable,
    output logic             o_an_restart,
    output logic             o_power_down,
    output logic             o_isolate,
    output logic             o_col,
    output logic             o_rx_dead,
    output logic             o_soft_reset
);
    // link pins cross into the core clock through two flops each
    logic [2:0] mdc_sync_reg;
    logic [1:0] mdio_sync_reg;
    always_ff @(posedge i_core_clk) begin
        mdc_sync_reg  <= {mdc_sync_reg[1:0], link.mdc};
        mdio_sync_reg <= {mdio_sync_reg[0], link.mdio};
    end
    wire mdc_rise = mdc_sync_reg[1] & ~mdc_sync_reg[2];
    wire mdio_in  = mdio_sync_reg[1];

    // frame engine state
    frame_state_type state_reg;
    logic [5:0]      cnt_reg;
    logic [15:0]     shift_reg;
    logic [15:0]     rdata_reg;
    logic            dev_o_reg;
    logic            dev_oe_reg;

    // control and latch state
    logic [15:0] ctrl_reg;
    logic [15:0] advert_reg;
    logic [15:0] vcfg_reg;
    logic [15:0] vstat_reg;
    logic [15:0] tenbt_reg;
    logic        rf_reg;
    logic        link_reg;
    logic        jab_reg;
    logic        restart_reg;
    logic [31:0] rst_cnt_reg;
    logic [31:0] dead_cnt_reg;
    logic        loop_prev_reg;

    wire soft_busy = (rst_cnt_reg != 32'h0);
    wire regs_init = i_reset | soft_busy;
    wire an_en     = ctrl_reg[`CTRL_AN_ENABLE_BIT];
    wire speed_eff = an_en ? i_an_speed_100 : ctrl_reg[`CTRL_SPEED_BIT];
    wire dup_eff   = an_en ? i_an_full_duplex : ctrl_reg[`CTRL_DUPLEX_BIT];

    // header fields, captured msb first behind the start bit
    wire [1:0] hdr_start = shift_reg[13:12];
    wire [1:0] hdr_op    = shift_reg[11:10];
    wire [4:0] hdr_phy   = shift_reg[9:5];
    wire [4:0] hdr_reg   = shift_reg[4:0];
    wire       hdr_ok    = (hdr_start == 2'b01) && (hdr_op == 2'b10 || hdr_op == 2'b01)
                           && (hdr_phy == PHY_ADDR);
    wire       hdr_read  = (hdr_op == 2'b10);
    wire       hdr_done  = mdc_rise && state_reg == st_header
                           && cnt_reg == 6'(`HEADER_BITS); // at first turnaround rise
    wire [15:0] wr_data  = {shift_reg[14:0], mdio_in};
    wire       wr_done   = mdc_rise && state_reg == st_data && !dev_oe_reg
                           && cnt_reg == 6'(`DATA_BITS - 1);
    logic [4:0] addr_reg;
    wire       wr_ctrl   = wr_done && addr_reg == `OFS_BASIC_CONTROL;
    wire       rd_status = hdr_done && hdr_ok && hdr_read
                           && hdr_reg == `OFS_BASIC_STATUS;

    // read view; control bits 6-0 and status 10-7 stay zero
    wire [15:0] ctrl_view = {soft_busy, ctrl_reg[14], speed_eff, ctrl_reg[12:10],
                             restart_reg, dup_eff, ctrl_reg[7], 7'h00};
    wire [15:0] stat_view = {1'b0, `STATUS_CAPS, 4'h0, 1'b0,
                             i_an_complete, rf_reg, 1'b1, link_reg, jab_reg, 1'b1};
    logic [15:0] rd_mux;
    always_comb begin
        case (hdr_reg)
            `OFS_BASIC_CONTROL:   rd_mux = ctrl_view;
            `OFS_BASIC_STATUS:    rd_mux = stat_view;
            `OFS_PHY_ID_HIGH:     rd_mux = ID_HIGH;
            `OFS_PHY_ID_LOW:      rd_mux = ID_LOW;
            `OFS_NEG_ADVERT:      rd_mux = advert_reg;
            `OFS_PARTNER_ABILITY: rd_mux = i_partner_ability;
            `OFS_NEG_EXPANSION:   rd_mux = i_neg_expansion;
            `OFS_VENDOR_CONFIG:   rd_mux = vcfg_reg;
            `OFS_VENDOR_CFG_STAT: rd_mux = vstat_reg;
            `OFS_TEN_BASE_T_CFG:  rd_mux = tenbt_reg;
            default:              rd_mux = 16'h0000;
        endcase
    end

    // frame receiver: only a full run of ones may open a frame
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state_reg  <= st_preamble;
            cnt_reg    <= 6'h00;
            shift_reg  <= 16'h0000;
            rdata_reg  <= 16'h0000;
            addr_reg   <= 5'h00;
            dev_o_reg  <= 1'b0;
            dev_oe_reg <= 1'b0;
        end else if (mdc_rise) begin
            case (state_reg)
                st_preamble: begin
                    dev_oe_reg <= 1'b0;
                    if (mdio_in) begin
                        if (cnt_reg != 6'(`PREAMBLE_ONES))
                            cnt_reg <= cnt_reg + 6'h01;
                    end else if (cnt_reg == 6'(`PREAMBLE_ONES)) begin
                        state_reg <= st_header;
                        cnt_reg   <= 6'h01;
                        shift_reg <= 16'h0000;
                    end else begin
                        cnt_reg <= 6'h00;
                    end
                end
                st_header: begin
                    shift_reg <= {shift_reg[14:0], mdio_in};
                    cnt_reg   <= cnt_reg + 6'h01;
                    if (hdr_done) begin
                        state_reg <= hdr_ok ? st_turn : st_preamble;
                        cnt_reg   <= 6'h00;
                        addr_reg  <= hdr_reg;
                        rdata_reg <= rd_mux;
                        dev_oe_reg <= 1'b0;
                        shift_reg <= {15'h0000, hdr_read};
                    end
                end
                st_turn: begin
                    // second turnaround bit: a read drives zero here
                    state_reg  <= st_data;
                    dev_oe_reg <= shift_reg[0];
                    dev_o_reg  <= 1'b0;
                end
                st_data: begin
                    cnt_reg   <= cnt_reg + 6'h01;
                    shift_reg <= wr_data;
                    dev_o_reg <= rdata_reg[15];
                    rdata_reg <= {rdata_reg[14:0], 1'b0};
                    if (cnt_reg == 6'(`DATA_BITS - 1)) begin
                        state_reg <= st_preamble;
                        cnt_reg   <= 6'h00;
                    end
                end
                default: state_reg <= st_preamble;
            endcase
        end else if (state_reg == st_preamble && dev_oe_reg && mdc_sync_reg[2]
                     && !mdc_sync_reg[1]) begin
            dev_oe_reg <= 1'b0; // release after the last data bit is sampled
        end
    end
    assign link.dev_o  = dev_o_reg;
    assign link.dev_oe = dev_oe_reg;

    // soft reset sequencer holds registers at default until done
    always_ff @(posedge i_core_clk) begin
        if (i_reset)
            rst_cnt_reg <= 32'h0;
        else if (wr_ctrl && wr_data[`CTRL_RESET_BIT] && !soft_busy)
            rst_cnt_reg <= 32'(RESET_CYCLES);
        else if (soft_busy)
            rst_cnt_reg <= rst_cnt_reg - 32'h1;
    end

    // writable registers; reserved and fixed bits are masked off
    always_ff @(posedge i_core_clk) begin
        if (regs_init) begin
            ctrl_reg   <= `RST_BASIC_CONTROL;
            advert_reg <= `RST_NEG_ADVERT;
            vcfg_reg   <= `RST_VENDOR_CONFIG;
            vstat_reg  <= `RST_VENDOR_CFG_STAT;
            tenbt_reg  <= `RST_TEN_BASE_T_CFG;
        end else if (wr_done) begin
            case (addr_reg)
                `OFS_BASIC_CONTROL:   ctrl_reg   <= {1'b0, wr_data[14:10], 1'b0,
                                                     wr_data[8:7], 7'h00};
                `OFS_NEG_ADVERT:      advert_reg <= wr_data & `MASK_NEG_ADVERT;
                `OFS_VENDOR_CONFIG:   vcfg_reg   <= wr_data;
                `OFS_VENDOR_CFG_STAT: vstat_reg  <= wr_data;
                `OFS_TEN_BASE_T_CFG:  tenbt_reg  <= wr_data;
                default:              ctrl_reg   <= ctrl_reg;
            endcase
        end
    end

    // restart request: a management zero never cancels it
    wire restart_set = wr_ctrl && wr_data[`CTRL_AN_RESTART_BIT] && wr_data[`CTRL_AN_ENABLE_BIT];
    always_ff @(posedge i_core_clk) begin
        if (regs_init)
            restart_reg <= 1'b0;
        else if (restart_set)
            restart_reg <= 1'b1;
        else if (i_an_initiated)
            restart_reg <= 1'b0;
    end

    // latches: the event wins over the clearing read
    wire rf_next   = (rd_status ? 1'b0 : rf_reg) | i_remote_fault
                     | i_partner_ability[`PARTNER_RF_BIT];
    wire link_next = (rd_status ? 1'b1 : link_reg) & i_link_up;
    wire jab_next  = (rd_status ? 1'b0 : jab_reg) | (i_jabber & ~speed_eff);
    always_ff @(posedge i_core_clk) begin
        if (regs_init) begin
            rf_reg   <= 1'b0;
            link_reg <= 1'b0;
            jab_reg  <= 1'b0;
        end else begin
            rf_reg   <= rf_next;
            link_reg <= link_next;
            jab_reg  <= jab_next;
        end
    end

    // loopback entry at 100M mutes receive for the descrambler relock time
    wire loop_rise = ctrl_reg[`CTRL_LOOPBACK_BIT] & ~loop_prev_reg;
    always_ff @(posedge i_core_clk) begin
        if (regs_init) begin
            loop_prev_reg <= 1'b0;
            dead_cnt_reg  <= 32'h0;
        end else begin
            loop_prev_reg <= ctrl_reg[`CTRL_LOOPBACK_BIT];
            if (loop_rise && speed_eff)
                dead_cnt_reg <= 32'(DEAD_CYCLES);
            else if (dead_cnt_reg != 32'h0)
                dead_cnt_reg <= dead_cnt_reg - 32'h1;
        end
    end

    // outputs to the phy core, all registered
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_loopback    <= 1'b0;
            o_speed_100   <= 1'b1;
            o_full_duplex <= 1'b1;
            o_an_enable   <= 1'b1;
            o_an_restart  <= 1'b0;
            o_power_down  <= 1'b0;
            o_isolate     <= 1'b0;
            o_col         <= 1'b0;
            o_rx_dead     <= 1'b0;
            o_soft_reset  <= 1'b0;
        end else begin
            o_loopback    <= ctrl_reg[`CTRL_LOOPBACK_BIT];
            o_speed_100   <= speed_eff;
            o_full_duplex <= dup_eff;
            o_an_enable   <= an_en;
            o_an_restart  <= restart_reg;
            o_power_down  <= ctrl_reg[`CTRL_POWER_DOWN_BIT];
            o_isolate     <= ctrl_reg[`CTRL_ISOLATE_BIT];
            o_col         <= ctrl_reg[`CTRL_COL_TEST_BIT] & i_tx_en;
            o_rx_dead     <= (dead_cnt_reg != 32'h0);
            o_soft_reset  <= soft_busy;
        end
    end
endmodule
`default_nettype wire

/* core/mdio_host_ctrl.sv */
// axi4-lite reached controller that bit-bangs the management link
`timescale 1ns/1ps
`default_nettype none
`include "phy_mgmt_defines.svh"
module mdio_host_ctrl
    import phy_mgmt_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_reset,
    input  wire logic [3:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [3:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    mdio_link_if.host        link
);
    logic       aw_have_reg;
    logic       w_have_reg;
    logic [3:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic       mdc_reg;
    logic       mdo_reg;
    logic       drive_reg;
    logic [1:0] mdi_sync_reg;

    // address and data taken in either order, answer once both are held
    wire aw_take  = i_awvalid & o_awready;
    wire w_take   = i_wvalid & o_wready;
    wire wr_go    = aw_have_reg & w_have_reg & ~o_bvalid;
    wire wr_hit   = (aw_addr_reg == `HOST_MGMT_CTRL_ADDR);
    wire wr_ok    = wr_hit | (aw_addr_reg == `HOST_MGMT_STAT_ADDR);
    wire ar_take  = i_arvalid & o_arready;
    wire [31:0] ctrl_view = {13'h0000, drive_reg, mdo_reg, mdc_reg, 16'h0000};
    wire [31:0] stat_view = {31'h00000000, mdi_sync_reg[1]};
    wire rd_ctrl  = (i_araddr == `HOST_MGMT_CTRL_ADDR);
    wire rd_stat  = (i_araddr == `HOST_MGMT_STAT_ADDR);

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_awready   <= 1'b1;
            o_wready    <= 1'b1;
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
            o_bvalid    <= 1'b0;
            o_bresp     <= `AXI_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= i_awaddr;
                o_awready   <= 1'b0;
            end
            if (w_take) begin
                w_have_reg <= 1'b1;
                w_data_reg <= i_wdata;
                w_strb_reg <= i_wstrb;
                o_wready   <= 1'b0;
            end
            if (wr_go) begin
                o_bvalid <= 1'b1;
                o_bresp  <= wr_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end
            if (o_bvalid && i_bready) begin
                o_bvalid    <= 1'b0;
                aw_have_reg <= 1'b0;
                w_have_reg  <= 1'b0;
                o_awready   <= 1'b1;
                o_wready    <= 1'b1;
            end
        end
    end

    // link pins: software toggles clock and data to build frames
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            mdc_reg   <= 1'b0;
            mdo_reg   <= 1'b1;
            drive_reg <= 1'b0;
        end else if (wr_go && wr_hit && w_strb_reg[2]) begin
            mdc_reg   <= w_data_reg[`HOST_CLOCK_BIT];
            mdo_reg   <= w_data_reg[`HOST_DATA_OUT_BIT];
            drive_reg <= w_data_reg[`HOST_DRIVE_BIT];
        end
    end
    assign link.mdc     = mdc_reg;
    assign link.host_o  = mdo_reg;
    assign link.host_oe = drive_reg;

    // line level read back through two flops
    always_ff @(posedge i_core_clk) begin
        mdi_sync_reg <= {mdi_sync_reg[0], link.mdio};
    end

    // read channel, one outstanding read
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= `AXI_RESP_OKAY;
        end else if (ar_take) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= rd_ctrl ? ctrl_view : (rd_stat ? stat_view : 32'h00000000);
            o_rresp   <= (rd_ctrl | rd_stat) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* tb/phy_mgmt_assertions.sv */
// protocol checker for the serial management link
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_assertions (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic mdc,
    input wire logic host_o,
    input wire logic host_oe,
    input wire logic dev_o,
    input wire logic dev_oe,
    input wire logic mdio
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    // the link leaves reset idle, so the first preamble is seen whole
    reset_idle_a: assert property ($fell(i_reset) |-> !mdc && host_o && !host_oe && !dev_oe)
        else $error("link not idle after reset");
    no_contention_a: assert property (!(host_oe && dev_oe))
        else $error("both ends drive the data line");
    ta_zero_a: assert property ($rose(dev_oe) |-> !dev_o)
        else $error("turnaround bit not zero");
    turn_order_a: assert property ($rose(dev_oe) |-> !$past(host_oe, 2))
        else $error("phy drives before host released");
    drive_span_a: assert property ($rose(dev_oe) |-> dev_oe [*8])
        else $error("phy drive dropped early");
    release_low_a: assert property ($fell(dev_oe) |-> !mdc)
        else $error("phy released outside clock low");
    // data may only move after a clock rise, never while the clock is low
    shift_high_a: assert property (dev_oe && $past(dev_oe) && $changed(dev_o) |-> mdc)
        else $error("phy data changed while clock low");
    pullup_a: assert property (!host_oe && !dev_oe |-> mdio)
        else $error("released line not high");
    cover property ($rose(dev_oe));
    cover property ($fell(dev_oe));
    cover property ($rose(host_oe));
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench: host controller and phy register set across the link
`timescale 1ns/1ps
`default_nettype none
`include "phy_mgmt_defines.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    logic core_clk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'hf;
    logic [31:0] wdata = 0, rv;
    logic link_up = 0, remote_fault = 0, jabber = 0, an_complete = 0, tx_en = 0;
    logic an_speed_100 = 1, an_full_duplex = 1, an_initiated = 0, saw_sr = 0;
    logic [15:0] partner_ab = 16'h00a1, neg_exp = 16'h0001, fd;
    logic [1:0] rs;
    wire awready, wready, bvalid, arready, rvalid, loopback, speed_100, full_duplex, an_enable;
    wire an_restart, power_down, isolate, col, rx_dead, soft_reset;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int miscompares = 0, check_count = 0, cyc = 0;
    logic [4:0] offs [13] = '{0, 1, 2, 3, 4, 5, 6, 7, 15, 16, 17, 18, 19};
    logic [15:0] exps [13] = '{16'h3100, 16'h7809, 16'h1234, 16'h5670, 16'h01e1, 16'h00a1,
        16'h0001, 0, 0, 0, 16'hf010, 16'h7800, 0};
    always #5 core_clk = ~core_clk;
    mdio_link_if link_if();
    mdio_host_ctrl mdio_host_ctrl_inst (.i_core_clk(core_clk), .i_reset(reset),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
        .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .link(link_if));
    // short dead time keeps the loopback case within the run
    phy_mgmt_regs #(.DEAD_CYCLES(50)) phy_mgmt_regs_inst (.i_core_clk(core_clk),
        .i_reset(reset), .link(link_if), .i_link_up(link_up), .i_remote_fault(remote_fault),
        .i_jabber(jabber), .i_an_complete(an_complete), .i_an_speed_100(an_speed_100),
        .i_an_full_duplex(an_full_duplex), .i_an_initiated(an_initiated),
        .i_partner_ability(partner_ab), .i_neg_expansion(neg_exp), .i_tx_en(tx_en),
        .o_loopback(loopback), .o_speed_100(speed_100), .o_full_duplex(full_duplex),
        .o_an_enable(an_enable), .o_an_restart(an_restart), .o_power_down(power_down),
        .o_isolate(isolate), .o_col(col), .o_rx_dead(rx_dead), .o_soft_reset(soft_reset));
    phy_mgmt_assertions phy_mgmt_assertions_inst (.i_core_clk(core_clk), .i_reset(reset),
        .mdc(link_if.mdc), .host_o(link_if.host_o), .host_oe(link_if.host_oe),
        .dev_o(link_if.dev_o), .dev_oe(link_if.dev_oe), .mdio(link_if.mdio));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // hang guard, well above the expected run length
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (soft_reset) saw_sr <= 1'b1;
        if (cyc == 90000) begin
            miscompares++;
            give_verdict();
        end
    end
    // idle gap keeps every clock level at least five core cycles
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        repeat (2) @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [3:0] a);
        repeat (2) @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rv = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    // one link bit: clock low with data set, then clock high
    task automatic bit_out(input logic drv, input logic d);
        axw(4'h0, {13'h0, drv, d, 1'b0, 16'h0});
        axw(4'h0, {13'h0, drv, d, 1'b1, 16'h0});
    endtask
    task automatic frame(input int pre, input logic [4:0] pa, input logic [4:0] ra,
                         input logic rd, input logic [15:0] d);
        logic [31:0] seq;
        seq = {2'b01, rd, !rd, pa, ra, 2'b10, d};
        repeat (pre) bit_out(1'b1, 1'b1);
        for (int i = 31; i >= 0; i--) if (!rd || i > 17) bit_out(1'b1, seq[i]);
        if (rd) begin
            bit_out(1'b0, 1'b1);
            bit_out(1'b0, 1'b1);
            for (int i = 0; i < 16; i++) begin
                bit_out(1'b0, 1'b1);
                repeat (3) @(posedge core_clk); // sample while clock high
                axr(4'h4);
                fd = {fd[14:0], rv[0]};
            end
        end
        bit_out(1'b0, 1'b1);
        axw(4'h0, 32'h0);
    endtask
    task automatic rd_chk(input logic [4:0] ra, input logic [15:0] e);
        frame(32, 5'h01, ra, 1'b1, 16'h0);
        `CHK(fd, e)
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        for (int i = 0; i < 13; i++) rd_chk(offs[i], exps[i]);
        axw(4'h8, 32'h0);
        `CHK(rs, `AXI_RESP_SLVERR)
        axr(4'h8);
        `CHK(rs, `AXI_RESP_SLVERR)
        $display("map and host bus done");
        frame(32, 5'h01, 5'h00, 1'b0, 16'h217f);
        rd_chk(5'h00, 16'h2100);
        `CHK({speed_100, full_duplex, an_enable}, 3'b110)
        frame(32, 5'h01, 5'h00, 1'b0, 16'h0c80);
        rd_chk(5'h00, 16'h0c80);
        `CHK({speed_100, full_duplex, power_down, isolate}, 4'b0011)
        tx_en <= 1'b1;
        repeat (3) @(posedge core_clk);
        `CHK(col, 1'b1)
        tx_en <= 1'b0;
        repeat (3) @(posedge core_clk);
        `CHK(col, 1'b0)
        $display("forced mode done");
        link_up <= 1'b1;
        rd_chk(5'h01, 16'h7809);
        link_up <= 1'b0;
        remote_fault <= 1'b1;
        jabber <= 1'b1;
        repeat (3) @(posedge core_clk);
        link_up <= 1'b1;
        remote_fault <= 1'b0;
        jabber <= 1'b0;
        an_complete <= 1'b1;
        rd_chk(5'h01, 16'h783b);
        rd_chk(5'h01, 16'h782d);
        $display("latches done");
        // no preamble, then a foreign phy address: both must be ignored
        frame(0, 5'h01, 5'h00, 1'b0, 16'h1000);
        frame(32, 5'h02, 5'h00, 1'b0, 16'h1000);
        rd_chk(5'h00, 16'h0c80);
        frame(32, 5'h01, 5'h00, 1'b0, 16'h8000);
        rd_chk(5'h00, 16'h3100);
        `CHK({saw_sr, power_down, isolate}, 3'b100)
        frame(32, 5'h01, 5'h00, 1'b0, 16'h1200);
        `CHK(an_restart, 1'b1)
        an_initiated <= 1'b1;
        an_speed_100 <= 1'b0;
        @(posedge core_clk);
        an_initiated <= 1'b0;
        repeat (3) @(posedge core_clk);
        `CHK({an_restart, speed_100}, 2'b00)
        rd_chk(5'h00, 16'h1100);
        an_speed_100 <= 1'b1;
        frame(32, 5'h01, 5'h00, 1'b0, 16'h5100);
        `CHK({loopback, rx_dead}, 2'b11)
        repeat (50) @(posedge core_clk);
        `CHK(rx_dead, 1'b0)
        frame(32, 5'h01, 5'h04, 1'b0, 16'hffff);
        rd_chk(5'h04, 16'h3dff);
        $display("control actions done");
        give_verdict();
    end
endmodule
`default_nettype wire
